// >>> src/energy_guard_pkg.sv
// constants shared by the energy guard design files
package energy_guard_pkg;
	// clock and timing
	localparam int CLOCK_PERIOD_NS = 100;
	localparam int TICK_NS = 10000;
	localparam int TICK_CYCLES = TICK_NS / CLOCK_PERIOD_NS;
	localparam int SECOND_NS = 1000000000;
	localparam int TICKS_PER_SECOND = SECOND_NS / TICK_NS;

	// register addresses
	localparam logic [9:0] ADDR_COOL_CTRL = 10'h015;
	localparam logic [9:0] ADDR_ENERGY_LIMIT = 10'h016;
	localparam logic [9:0] ADDR_ENERGY_TOTAL = 10'h017;
	localparam logic [9:0] ADDR_LOAD_ENABLE = 10'h200;
	localparam logic [9:0] ADDR_GAIN_SELECT = 10'h201;

	// reset values
	localparam logic [15:0] RST_COOL_CTRL = 16'h0505;
	localparam logic [15:0] RST_ENERGY_LIMIT = 16'h9ba3;
	localparam logic [15:0] RST_ENERGY_TOTAL = 16'h0000;
	localparam logic [15:0] RST_LOAD_ENABLE = 16'h0000;
	localparam logic [1:0] RST_GAIN_SELECT = 2'h0;

	// cool-down control fields
	localparam int DECR_LSB = 8;
	localparam int OVR_LSB = 6;
	localparam int STEP_LSB = 4;
	localparam int SEC_LSB = 0;

	// load enable pair fields
	localparam int LOAD_ENABLE_B_BIT = 15;
	localparam int LOAD_ENABLE_A_BIT = 14;
	localparam logic [15:0] LOAD_ENABLE_MASK = 16'hc00f;

	// accumulator scaling
	localparam int ACC_W = 24;
	localparam int LIMIT_SHIFT = 7;
	localparam logic [7:0] ADC_FULL_SCALE = 8'hff;

	typedef enum logic [1:0] {
		ST_ACCUM = 2'b01,
		ST_COOL = 2'b10
	} guard_state_type;
endpackage

// >>> src/gain_decoder.sv
// gain select code to thermometer code for the amplifier stages
`timescale 1ns/10ps
module gain_decoder (
	// clocking
	input wire logic clock,
	input wire logic nrst,
	input wire logic ce,
	// code in, stages out
	input wire logic [1:0] code,
	output logic [3:0] therm
);
	logic [3:0] therm_r, therm_nxt;

	always_comb begin
		therm_nxt = therm_r;
		if (ce) begin
			case (code)
				2'h0: therm_nxt = 4'h1;
				2'h1: therm_nxt = 4'h3;
				2'h2: therm_nxt = 4'h7;
				default: therm_nxt = 4'hf;
			endcase
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			therm_r <= 4'h1;
		end else begin
			therm_r <= therm_nxt;
		end
	end

	assign therm = therm_r;
endmodule // gain_decoder

// >>> src/pulse_load_energy_guard.sv
// energy guard for the pulsed load: registers, accumulator and cool-down timing
// Behaviour
// - cool-down field is whole seconds
// - zero seconds disables cool-down entirely
// - enter cool-down when energy exceeds limit
// - compare against limit times 128
// - add scaled sample every 10 us
// - accumulator readable, resets to zero
// - load on only with both enables
// - enables cleared after reset
// - gain code drives thermometer stages
// - codes give gain 1, 2, 5, 10
// - subtract decrement every cool-down step
// - full-scale sample multiplied by over-range factor
`timescale 1ns/10ps
module pulse_load_energy_guard #(
	parameter int TICKS_PER_SEC = energy_guard_pkg::TICKS_PER_SECOND
) (
	// clocking
	input wire logic clock,
	input wire logic nrst,
	input wire logic ce,
	// decoded serial-port register access
	input wire logic [9:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic reg_rvalid,
	// converter samples
	input wire logic [7:0] adc_sample,
	// load and amplifier control
	output logic load_on,
	output logic pulse_off,
	output logic [3:0] gain_therm
);
	localparam int AW = energy_guard_pkg::ACC_W;
	localparam int SW = $clog2(TICKS_PER_SEC + 1);
	localparam logic [SW-1:0] SEC_LAST = SW'(TICKS_PER_SEC - 1);
	localparam logic [AW-1:0] ACC_MAX = '1;

	logic tick;
	logic [15:0] ctrl_r, ctrl_nxt;
	logic [15:0] limit_r, limit_nxt;
	logic [15:0] enable_r, enable_nxt;
	logic [1:0] gain_r, gain_nxt;
	logic [AW-1:0] acc_r, acc_nxt;
	energy_guard_pkg::guard_state_type state_r, state_nxt;
	logic [3:0] step_cnt_r, step_cnt_nxt;
	logic [SW-1:0] sec_cnt_r, sec_cnt_nxt;
	logic [3:0] sec_left_r, sec_left_nxt;
	logic [15:0] rdata_r, rdata_nxt;
	logic rvalid_r, rvalid_nxt;
	logic load_on_r, load_on_nxt;
	logic pulse_off_r, pulse_off_nxt;

	logic [7:0] cool_decrement;
	logic [1:0] overrange_multiplier;
	logic [1:0] cool_step_period;
	logic [3:0] cool_period_seconds;
	logic [AW-1:0] limit_scaled;
	logic [11:0] sample_scaled;
	logic [AW:0] acc_sum;
	logic [3:0] step_len;
	logic over_limit;
	logic step_done;

	////////////////////////////////////////////////////////////////////////
	// field views and arithmetic

	assign cool_decrement = ctrl_r[energy_guard_pkg::DECR_LSB +: 8];
	assign overrange_multiplier = ctrl_r[energy_guard_pkg::OVR_LSB +: 2];
	assign cool_step_period = ctrl_r[energy_guard_pkg::STEP_LSB +: 2];
	assign cool_period_seconds = ctrl_r[energy_guard_pkg::SEC_LSB +: 4];
	assign limit_scaled = AW'({limit_r, 7'h00});
	assign over_limit = acc_r > limit_scaled;
	assign acc_sum = {1'b0, acc_r} + (AW + 1)'(sample_scaled);
	assign step_len = 4'h1 << cool_step_period;
	assign step_done = (step_cnt_r + 4'h1) == step_len;

	// over-range factor 1, 4, 8, 16
	always_comb begin
		sample_scaled = {4'h0, adc_sample};
		if (adc_sample == energy_guard_pkg::ADC_FULL_SCALE) begin
			case (overrange_multiplier)
				2'h0: sample_scaled = {4'h0, adc_sample};
				2'h1: sample_scaled = {2'h0, adc_sample, 2'h0};
				2'h2: sample_scaled = {1'h0, adc_sample, 3'h0};
				default: sample_scaled = {adc_sample, 4'h0};
			endcase
		end
	end

	tick_timer #(
		.CYCLES(energy_guard_pkg::TICK_CYCLES)
	) u_tick (
		.clock(clock),
		.nrst(nrst),
		.ce(ce),
		.tick(tick)
	);

	gain_decoder u_gain (
		.clock(clock),
		.nrst(nrst),
		.ce(ce),
		.code(gain_r),
		.therm(gain_therm)
	);

	////////////////////////////////////////////////////////////////////////
	// register file

	always_comb begin
		ctrl_nxt = ctrl_r;
		limit_nxt = limit_r;
		enable_nxt = enable_r;
		gain_nxt = gain_r;
		rdata_nxt = rdata_r;
		rvalid_nxt = 1'b0;
		if (ce && reg_wr) begin
			if (reg_addr == energy_guard_pkg::ADDR_COOL_CTRL) begin
				ctrl_nxt = reg_wdata;
			end else if (reg_addr == energy_guard_pkg::ADDR_ENERGY_LIMIT) begin
				limit_nxt = reg_wdata;
			end else if (reg_addr == energy_guard_pkg::ADDR_LOAD_ENABLE) begin
				enable_nxt = reg_wdata & energy_guard_pkg::LOAD_ENABLE_MASK;
			end else if (reg_addr == energy_guard_pkg::ADDR_GAIN_SELECT) begin
				gain_nxt = reg_wdata[1:0];
			end
		end
		if (!ce) begin
			rvalid_nxt = rvalid_r;
		end else if (reg_rd) begin
			rvalid_nxt = 1'b1;
			if (reg_addr == energy_guard_pkg::ADDR_COOL_CTRL) begin
				rdata_nxt = ctrl_r;
			end else if (reg_addr == energy_guard_pkg::ADDR_ENERGY_LIMIT) begin
				rdata_nxt = limit_r;
			end else if (reg_addr == energy_guard_pkg::ADDR_ENERGY_TOTAL) begin
				rdata_nxt = acc_r[energy_guard_pkg::LIMIT_SHIFT +: 16];
			end else if (reg_addr == energy_guard_pkg::ADDR_LOAD_ENABLE) begin
				rdata_nxt = enable_r;
			end else if (reg_addr == energy_guard_pkg::ADDR_GAIN_SELECT) begin
				rdata_nxt = {14'h0000, gain_r};
			end else begin
				rdata_nxt = 16'h0000;
			end
		end
		load_on_nxt = enable_nxt[energy_guard_pkg::LOAD_ENABLE_A_BIT] & enable_nxt[energy_guard_pkg::LOAD_ENABLE_B_BIT];
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ctrl_r <= energy_guard_pkg::RST_COOL_CTRL;
			limit_r <= energy_guard_pkg::RST_ENERGY_LIMIT;
			enable_r <= energy_guard_pkg::RST_LOAD_ENABLE;
			gain_r <= energy_guard_pkg::RST_GAIN_SELECT;
			rdata_r <= 16'h0000;
			rvalid_r <= 1'b0;
			load_on_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			limit_r <= limit_nxt;
			enable_r <= enable_nxt;
			gain_r <= gain_nxt;
			rdata_r <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
			load_on_r <= load_on_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// energy accumulator and cool-down sequencing

	always_comb begin
		state_nxt = state_r;
		acc_nxt = acc_r;
		step_cnt_nxt = step_cnt_r;
		sec_cnt_nxt = sec_cnt_r;
		sec_left_nxt = sec_left_r;
		if (ce) begin
			case (state_r)
				energy_guard_pkg::ST_ACCUM: begin
					if (cool_period_seconds != 4'h0 && over_limit) begin
						state_nxt = energy_guard_pkg::ST_COOL;
						sec_left_nxt = cool_period_seconds;
						sec_cnt_nxt = '0;
						step_cnt_nxt = 4'h0;
					end else if (tick) begin
						acc_nxt = acc_sum[AW] ? ACC_MAX : acc_sum[AW-1:0];
					end
				end
				energy_guard_pkg::ST_COOL: begin
					if (cool_period_seconds == 4'h0) begin
						state_nxt = energy_guard_pkg::ST_ACCUM;
					end else if (tick) begin
						if (step_done) begin
							step_cnt_nxt = 4'h0;
							acc_nxt = (acc_r > AW'(cool_decrement)) ? acc_r - AW'(cool_decrement) : '0;
						end else begin
							step_cnt_nxt = step_cnt_r + 4'h1;
						end
						// count down whole seconds, then resume
						if (sec_cnt_r == SEC_LAST) begin
							sec_cnt_nxt = '0;
							sec_left_nxt = sec_left_r - 4'h1;
							if (sec_left_r == 4'h1) begin
								state_nxt = energy_guard_pkg::ST_ACCUM;
							end
						end else begin
							sec_cnt_nxt = sec_cnt_r + SW'(1);
						end
					end
				end
				default: state_nxt = energy_guard_pkg::ST_ACCUM;
			endcase
		end
		pulse_off_nxt = state_nxt == energy_guard_pkg::ST_COOL;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_r <= energy_guard_pkg::ST_ACCUM;
			acc_r <= '0;
			step_cnt_r <= 4'h0;
			sec_cnt_r <= '0;
			sec_left_r <= 4'h0;
			pulse_off_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			acc_r <= acc_nxt;
			step_cnt_r <= step_cnt_nxt;
			sec_cnt_r <= sec_cnt_nxt;
			sec_left_r <= sec_left_nxt;
			pulse_off_r <= pulse_off_nxt;
		end
	end

	assign reg_rdata = rdata_r;
	assign reg_rvalid = rvalid_r;
	assign load_on = load_on_r;
	assign pulse_off = pulse_off_r;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	sequence accum_quiet_s;
		state_r == energy_guard_pkg::ST_ACCUM && ce && !(cool_period_seconds != 4'h0 && over_limit);
	endsequence

	sequence cool_entry_s;
		(state_r == energy_guard_pkg::ST_ACCUM) ##1 (state_r == energy_guard_pkg::ST_COOL);
	endsequence

	cool_enter_a: assert property ((state_r == energy_guard_pkg::ST_ACCUM && ce && cool_period_seconds != 4'h0 && over_limit)
		|=> state_r == energy_guard_pkg::ST_COOL && sec_left_r == $past(cool_period_seconds))
		else $error("cool-down not entered on limit crossing");

	limit_scale_a: assert property ((state_r == energy_guard_pkg::ST_ACCUM && acc_r <= {1'b0, limit_r, 7'h00})
		|=> state_r == energy_guard_pkg::ST_ACCUM)
		else $error("cool-down entered below scaled limit");

	zero_period_a: assert property ((ce && cool_period_seconds == 4'h0)
		|=> state_r == energy_guard_pkg::ST_ACCUM)
		else $error("cool-down active with zero duration");

	accum_tick_a: assert property ((accum_quiet_s and (tick && !acc_sum[AW]))
		|=> acc_r == $past(acc_r) + AW'($past(sample_scaled)))
		else $error("sample not accumulated on tick");

	accum_hold_a: assert property ((accum_quiet_s and !tick) |=> $stable(acc_r))
		else $error("accumulator moved between ticks");

	overrange_x16_a: assert property ((accum_quiet_s and (tick && adc_sample == 8'hff && overrange_multiplier == 2'h3
		&& !acc_sum[AW])) |=> acc_r == $past(acc_r) + AW'(12'hff0))
		else $error("full-scale sample not multiplied by 16");

	cool_decr_a: assert property ((state_r == energy_guard_pkg::ST_COOL && ce && tick && step_done
		&& cool_period_seconds != 4'h0 && acc_r > AW'(cool_decrement))
		|=> acc_r == $past(acc_r) - AW'($past(cool_decrement)))
		else $error("cool-down decrement missing");

	// pulse off on the first cycle of cool-down
	cool_pulse_a: assert property (cool_entry_s |-> pulse_off_r && sec_left_r != 4'h0)
		else $error("pulse current not off in cool-down");

	load_pair_a: assert property (load_on_r == (enable_r[15] & enable_r[14]))
		else $error("load enable not the and of both bits");

	gain_map_a: assert property (ce |=> gain_therm == {$past(gain_r) == 2'h3, $past(gain_r) != 2'h0 && $past(gain_r) != 2'h1,
		$past(gain_r) != 2'h0, 1'b1})
		else $error("gain thermometer code wrong");
endmodule // pulse_load_energy_guard

// >>> src/tick_timer.sv
// free-running divider that pulses once per 10 us tick
`timescale 1ns/10ps
module tick_timer #(
	parameter int CYCLES = energy_guard_pkg::TICK_CYCLES
) (
	// clocking
	input wire logic clock,
	input wire logic nrst,
	input wire logic ce,
	// tick out
	output logic tick
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	logic [CW-1:0] count_r, count_nxt;
	logic tick_r, tick_nxt;

	always_comb begin
		count_nxt = count_r;
		tick_nxt = 1'b0;
		if (ce) begin
			if (count_r == LAST) begin
				count_nxt = '0;
				tick_nxt = 1'b1;
			end else begin
				count_nxt = count_r + CW'(1);
			end
		end else begin
			tick_nxt = tick_r;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			count_r <= '0;
			tick_r <= 1'b0;
		end else begin
			count_r <= count_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick = tick_r;
endmodule // tick_timer

// >>> tb/tb.sv
// self-checking bench for the pulsed-load energy guard
`timescale 1ns/10ps
`define CHK(a, b, m) begin samples_checked++; if ((a) !== (b)) begin fail_count++; $display("[FAIL] %0t ns: %s", $time, m); end end
module tb;
	localparam int TPS = 4;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic ce = 1'b1;
	logic [9:0] reg_addr = 10'h000;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic reg_rvalid;
	logic [7:0] adc = 8'h00;
	logic load_on;
	logic pulse_off;
	logic [3:0] gain_therm;
	int fail_count = 0;
	int samples_checked = 0;

	always #50 clock = ~clock;

	// tick count shortened so a cool-down second lasts four ticks
	pulse_load_energy_guard #(.TICKS_PER_SEC(TPS)) dut_u (
		.clock(clock),
		.nrst(nrst),
		.ce(ce),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid),
		.adc_sample(adc),
		.load_on(load_on),
		.pulse_off(pulse_off),
		.gain_therm(gain_therm)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic results();
		if (fail_count == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic wr(input logic [9:0] a, input logic [15:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clock);
		reg_wr = 1'b0;
	endtask

	task automatic rd(input logic [9:0] a, output logic [15:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clock);
		reg_rd = 1'b0;
		`CHK(reg_rvalid, 1'b1, "read not answered")
		d = reg_rdata;
	endtask

	task automatic rst_pulse();
		@(negedge clock);
		nrst = 1'b0;
		repeat (2) @(negedge clock);
		nrst = 1'b1;
	endtask

	task automatic wait_pulse(input logic lvl, input int lim);
		int k;
		k = 0;
		while (pulse_off !== lvl && k < lim) begin
			@(negedge clock);
			k++;
		end
		`CHK(pulse_off, lvl, "pulse_off late")
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// generous bound: the whole sequence needs about 8500 cycles
	initial begin
		#2000000;
		fail_count++;
		results();
	end

	initial begin
		logic [9:0] ra [6];
		logic [15:0] rx [6];
		logic [15:0] ew [4];
		logic [15:0] er [4];
		logic el [4];
		logic [3:0] th [4];
		logic [7:0] smp [5];
		logic [1:0] ovc [5];
		logic [15:0] ovx [5];
		logic [15:0] v;
		time t0;
		int n;
		int lo;
		int hi;
		ra = '{10'h015, 10'h016, 10'h017, 10'h200, 10'h201, 10'h3ff};
		rx = '{16'h0505, 16'h9ba3, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
		ew = '{16'h8000, 16'h4000, 16'hffff, 16'h0000};
		er = '{16'h8000, 16'h4000, 16'hc00f, 16'h0000};
		el = '{1'b0, 1'b0, 1'b1, 1'b0};
		th = '{4'h1, 4'h3, 4'h7, 4'hf};
		smp = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hfe};
		ovc = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
		ovx = '{16'h000f, 16'h003f, 16'h007f, 16'h00ff, 16'h000f};
		repeat (16) @(negedge clock);
		nrst = 1'b1;
		`CHK(load_on, 1'b0, "load on after reset")
		`CHK(pulse_off, 1'b0, "cool-down after reset")
		`CHK(gain_therm, 4'h1, "gain after reset")
		for (int i = 0; i < 6; i++) begin
			rd(ra[i], v);
			`CHK(v, rx[i], "register reset value")
		end
		// accumulator is read-only
		wr(10'h017, 16'h1234);
		rd(10'h017, v);
		`CHK(v, 16'h0000, "accumulator took a write")
		for (int i = 0; i < 4; i++) begin
			wr(10'h200, ew[i]);
			rd(10'h200, v);
			`CHK(v, er[i], "enable readback")
			`CHK(load_on, el[i], "load enable pair")
		end
		for (int i = 0; i < 4; i++) begin
			wr(10'h201, {14'h3fff, i[1:0]});
			rd(10'h201, v);
			`CHK(v, {14'h0000, i[1:0]}, "gain readback")
			`CHK(gain_therm, th[i], "gain thermometer")
		end
		// clock enable low: a write must not be taken, the stages hold
		ce = 1'b0;
		wr(10'h201, 16'h0000);
		ce = 1'b1;
		`CHK(gain_therm, 4'hf, "gain moved with clock enable low")
		rd(10'h201, v);
		`CHK(v, 16'h0003, "write taken with clock enable low")
		// zero seconds with zero limit: accumulate eight ticks, never cool
		for (int i = 0; i < 5; i++) begin
			rst_pulse();
			wr(10'h015, {8'h05, ovc[i], 2'b00, 4'h0});
			wr(10'h016, 16'h0000);
			adc = smp[i];
			repeat (845) @(negedge clock);
			`CHK(pulse_off, 1'b0, "cool-down while disabled")
			rd(10'h017, v);
			`CHK(v, ovx[i], "scaled accumulation")
		end
		// limit 0x20 scales to 4096: one x16 full-scale tick (4080) stays below
		for (int s = 0; s < 4; s++) begin
			n = 1 << s;
			rst_pulse();
			wr(10'h016, 16'h0020);
			wr(10'h015, {8'h80, 2'b11, s[1:0], 4'h2});
			adc = 8'hff;
			repeat (146) @(negedge clock);
			`CHK(pulse_off, 1'b0, "entered below scaled limit")
			wait_pulse(1'b1, 100);
			t0 = $time;
			rd(10'h017, v);
			`CHK(v, 16'h003f, "accumulator at entry")
			repeat (650) @(negedge clock);
			rd(10'h017, v);
			lo = 63 - (6 + n - 1) / n;
			hi = 63 - 6 / n;
			`CHK(int'(v) >= lo && int'(v) <= hi, 1'b1, "cool-down decrement")
			wait_pulse(1'b0, 300);
			`CHK(($time - t0) / 100 inside {[790:810]}, 1'b1, "cool-down length")
		end
		// clearing the seconds field in mid cool-down ends it at once
		rst_pulse();
		wr(10'h016, 16'h0000);
		wr(10'h015, 16'h0501);
		adc = 8'hff;
		wait_pulse(1'b1, 200);
		wr(10'h015, 16'h0500);
		@(negedge clock);
		`CHK(pulse_off, 1'b0, "cool-down not aborted by zero seconds")
		results();
	end
endmodule // tb
